// ---- include/mem_cycle_pkg.sv ----
// constants for the low pin count memory cycle target
`default_nettype none
package mem_cycle_pkg;
    localparam logic [3:0] START_MEM_CODE   = 4'h0;
    localparam logic [1:0] CYC_MEM_CLASS    = 2'h1;
    localparam int         DIR_BIT          = 1;
    localparam logic [3:0] TURN_ONES_CODE   = 4'hf;
    localparam logic [3:0] WAIT_SYNC_CODE   = 4'h5;
    localparam logic [3:0] READY_SYNC_CODE  = 4'h0;
    localparam int         ADDR_NIBBLES     = 8;
    localparam int         WAIT_SYNC_COUNT  = 2;
    localparam int         ARRAY_SEL_BIT    = 23;
    localparam int         DECODED_ADDR_W   = 24;
endpackage : mem_cycle_pkg
`default_nettype wire

// ---- logic/nibble_drive.sv ----
// registered pin driver for the shared nibble bus
`timescale 1ns/1ps
`default_nettype none
module nibble_drive (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       drive_en,
    input  wire logic [3:0] drive_val,
    output logic      [3:0] bus_o,
    output logic            bus_oe_n
);
    logic [3:0] val_ff;
    logic       oe_n_ff;

    // drivers float after reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            val_ff  <= 4'hf;
            oe_n_ff <= 1'b1;
        end else begin
            val_ff  <= drive_val;
            oe_n_ff <= ~drive_en;
        end
    end

    assign bus_o    = val_ff;
    assign bus_oe_n = oe_n_ff;
endmodule // nibble_drive
`default_nettype wire

// ---- logic/lpc_memory_cycle_target.sv ----
// target state machine for memory read and write cycles on the nibble bus
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - a cycle starts only on the last 0000b nibble seen while frame strobe low
// - type nibble 010x on the second clock is a memory read, bit 0 ignored
// - type nibble 011x on the second clock is a memory write
// - clocks 3 to 10 carry a 32-bit address, high nibble first
// - host drives 1111b one clock then floats; device drives the next clock
// - on reads device drives wait sync 0101b on clocks 13 and 14
// - on reads device drives ready sync 0000b on clock 15
// - read data goes out on clocks 16 and 17, low nibble first
// - device drives 1111b one clock after its last field, then floats
// - the written byte is handed to the command logic
// - on writes device drives ready sync on clock 15, 1111b on 16, floats on 17
// - all nibbles are sampled on the rising clock edge
// - other cycle types float the bus and idle until frame strobe is high and no operation is pending
// - only the low 24 address bits decode; bit 23 picks array or registers
module lpc_memory_cycle_target #(
    parameter int WAIT_SYNCS = mem_cycle_pkg::WAIT_SYNC_COUNT
) (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        frame_strobe_n,
    input  wire logic [3:0]  mux_nibble_bus_i,
    output logic      [3:0]  mux_nibble_bus_o,
    output logic             mux_nibble_bus_oe_n,
    output logic      [23:0] access_addr,
    output logic             array_select,
    output logic             read_req,
    input  wire logic [7:0]  read_data,
    output logic      [7:0]  write_byte,
    output logic             write_strobe,
    output logic             cycle_busy,
    input  wire logic        op_pending
);
    // refuse wait counts the four-bit counter cannot serve
    if (WAIT_SYNCS < 1 || WAIT_SYNCS > 15) begin : g_bad_waits
        $error("WAIT_SYNCS out of range");
    end

    typedef enum logic [12:0] {
        ST_IDLE  = 13'h0001,
        ST_TYPE  = 13'h0002,
        ST_ADDR  = 13'h0004,
        ST_WDATA = 13'h0008,
        ST_HTAR0 = 13'h0010,
        ST_HTAR1 = 13'h0020,
        ST_WAIT  = 13'h0040,
        ST_READY = 13'h0080,
        ST_DLO   = 13'h0100,
        ST_DHI   = 13'h0200,
        ST_DTAR0 = 13'h0400,
        ST_DTAR1 = 13'h0800,
        ST_SKIP  = 13'h1000
    } cyc_state_t;

    cyc_state_t  state_ff, nxt_state;
    logic        is_write_ff;
    logic [31:0] addr_ff;
    logic [2:0]  nib_cnt_ff;
    logic [3:0]  wait_cnt_ff;
    logic [7:0]  wbyte_ff;
    logic [7:0]  rbyte_ff;
    logic        wstb_ff, rreq_ff, busy_ff;
    logic        skip_pend_ff;

    // input decoding
    wire start_seen  = !frame_strobe_n && (mux_nibble_bus_i == mem_cycle_pkg::START_MEM_CODE);
    wire type_is_mem = mux_nibble_bus_i[3:2] == mem_cycle_pkg::CYC_MEM_CLASS;
    wire type_is_wr  = mux_nibble_bus_i[mem_cycle_pkg::DIR_BIT];
    wire addr_last   = nib_cnt_ff == 3'(mem_cycle_pkg::ADDR_NIBBLES - 1);
    wire wait_last   = wait_cnt_ff == 4'(WAIT_SYNCS - 1);

    // next state
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE:  nxt_state = start_seen ? ST_TYPE : ST_IDLE;
            ST_TYPE:  begin
                if (!frame_strobe_n)
                    nxt_state = start_seen ? ST_TYPE : ST_IDLE;
                else
                    nxt_state = type_is_mem ? ST_ADDR : ST_SKIP;
            end
            ST_ADDR:  begin
                if (addr_last)
                    nxt_state = is_write_ff ? ST_WDATA : ST_HTAR0;
            end
            ST_WDATA: nxt_state = (nib_cnt_ff[0]) ? ST_HTAR0 : ST_WDATA;
            ST_HTAR0: nxt_state = ST_HTAR1;
            ST_HTAR1: nxt_state = is_write_ff ? ST_READY : ST_WAIT;
            ST_WAIT:  nxt_state = wait_last ? ST_READY : ST_WAIT;
            ST_READY: nxt_state = is_write_ff ? ST_DTAR0 : ST_DLO;
            ST_DLO:   nxt_state = ST_DHI;
            ST_DHI:   nxt_state = ST_DTAR0;
            ST_DTAR0: nxt_state = ST_DTAR1;
            ST_DTAR1: nxt_state = ST_IDLE;
            ST_SKIP:  nxt_state = (frame_strobe_n && !op_pending) ? ST_IDLE : ST_SKIP;
            default:  nxt_state = ST_IDLE;
        endcase
    end

    // frame low with a 0000b nibble restarts from any state
    wire restart = start_seen && state_ff != ST_IDLE && state_ff != ST_TYPE;
    wire cyc_state_t next_q = restart ? ST_TYPE : nxt_state;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) state_ff <= ST_IDLE;
        else         state_ff <= next_q;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)                                         is_write_ff <= 1'b0;
        else if (state_ff == ST_TYPE && frame_strobe_n)       is_write_ff <= type_is_wr;
    end

    // nibble counter for address and write data
    wire cnt_run = state_ff == ST_ADDR || state_ff == ST_WDATA;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)                 nib_cnt_ff <= 3'h0;
        else if (!cnt_run)           nib_cnt_ff <= 3'h0;
        else if (addr_last)          nib_cnt_ff <= 3'h0;
        else                         nib_cnt_ff <= nib_cnt_ff + 3'h1;
    end

    // address shifts in high nibble first
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)                 addr_ff <= 32'h0000_0000;
        else if (state_ff == ST_ADDR) addr_ff <= {addr_ff[27:0], mux_nibble_bus_i};
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)                   wbyte_ff <= 8'h00;
        else if (state_ff == ST_WDATA) wbyte_ff <= {mux_nibble_bus_i, wbyte_ff[7:4]};
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)                  wait_cnt_ff <= 4'h0;
        else if (state_ff == ST_WAIT) wait_cnt_ff <= wait_cnt_ff + 4'h1;
        else                          wait_cnt_ff <= 4'h0;
    end

    // read request during host turnaround, data captured before ready sync
    wire nxt_rreq = state_ff == ST_HTAR0 && !is_write_ff;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)                   rbyte_ff <= 8'h00;
        else if (state_ff == ST_WAIT && wait_last) rbyte_ff <= read_data;
    end

    // byte handed on after high nibble
    wire nxt_wstb = state_ff == ST_WDATA && nib_cnt_ff[0] && !restart;
    wire nxt_busy = next_q != ST_IDLE && next_q != ST_SKIP && next_q != ST_TYPE;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wstb_ff <= 1'b0;
            rreq_ff <= 1'b0;
            busy_ff <= 1'b0;
            skip_pend_ff <= 1'b0;
        end else begin
            wstb_ff <= nxt_wstb;
            rreq_ff <= nxt_rreq;
            busy_ff <= nxt_busy;
            skip_pend_ff <= next_q == ST_SKIP;
        end
    end

    // pin value for the next clock, from the next state
    logic       nxt_drive;
    logic [3:0] nxt_val;
    always_comb begin
        nxt_drive = 1'b1;
        nxt_val   = mem_cycle_pkg::TURN_ONES_CODE;
        unique case (next_q)
            ST_WAIT:  nxt_val = mem_cycle_pkg::WAIT_SYNC_CODE;
            ST_READY: nxt_val = mem_cycle_pkg::READY_SYNC_CODE;
            ST_DLO:   nxt_val = (state_ff == ST_WAIT) ? read_data[3:0] : rbyte_ff[3:0];
            ST_DHI:   nxt_val = rbyte_ff[7:4];
            ST_DTAR0: nxt_val = mem_cycle_pkg::TURN_ONES_CODE;
            default:  nxt_drive = 1'b0;
        endcase
    end

    nibble_drive u_drive (
        .clk       (clk),
        .arst_n    (arst_n),
        .drive_en  (nxt_drive),
        .drive_val (nxt_val),
        .bus_o     (mux_nibble_bus_o),
        .bus_oe_n  (mux_nibble_bus_oe_n)
    );

    // low 24 bits decoded, bit 23 picks array
    assign access_addr  = addr_ff[mem_cycle_pkg::DECODED_ADDR_W-1:0];
    assign array_select = addr_ff[mem_cycle_pkg::ARRAY_SEL_BIT];
    assign write_byte   = wbyte_ff;
    assign write_strobe = wstb_ff;
    assign read_req     = rreq_ff;
    assign cycle_busy   = busy_ff;

    wait_after_tar_a: assert property (@(posedge clk) disable iff (!arst_n)
        state_ff == ST_HTAR1 && !is_write_ff |=> state_ff == ST_WAIT ##1 state_ff == ST_WAIT)
        else $error("wait syncs missing");
    ready_sync_val_a: assert property (@(posedge clk) disable iff (!arst_n)
        state_ff == ST_READY |-> !mux_nibble_bus_oe_n && mux_nibble_bus_o == 4'h0)
        else $error("ready sync wrong");
    read_nibbles_a: assert property (@(posedge clk) disable iff (!arst_n)
        state_ff == ST_DLO && !restart |=> mux_nibble_bus_o == $past(rbyte_ff[7:4]))
        else $error("high nibble wrong");
    dev_tar_a: assert property (@(posedge clk) disable iff (!arst_n)
        state_ff == ST_DTAR0 |-> mux_nibble_bus_o == 4'hf ##1 mux_nibble_bus_oe_n)
        else $error("turnaround wrong");
    float_idle_a: assert property (@(posedge clk) disable iff (!arst_n)
        state_ff inside {ST_IDLE, ST_ADDR, ST_HTAR0, ST_HTAR1, ST_SKIP} |-> mux_nibble_bus_oe_n)
        else $error("bus driven out of turn");
    write_strobe_a: assert property (@(posedge clk) disable iff (!arst_n)
        write_strobe |-> $past(state_ff, 2) == ST_WDATA)
        else $error("write strobe early");
    skip_float_a: assert property (@(posedge clk) disable iff (!arst_n)
        skip_pend_ff |-> mux_nibble_bus_oe_n)
        else $error("skip drives bus");
    write_ready_a: assert property (@(posedge clk) disable iff (!arst_n)
        state_ff == ST_HTAR1 && is_write_ff && !restart |=> state_ff == ST_READY ##1
        state_ff == ST_DTAR0)
        else $error("write ready order wrong");
    addr_len_a: assert property (@(posedge clk) disable iff (!arst_n || restart)
        $rose(state_ff == ST_ADDR) |-> (state_ff == ST_ADDR || start_seen) [*8])
        else $error("address too short");

    // wait sync value on the pins
    wait_sync_val_a: assert property (@(posedge clk) disable iff (!arst_n)
        state_ff == ST_WAIT |-> !mux_nibble_bus_oe_n && mux_nibble_bus_o == 4'h5)
        else $error("wait sync wrong");
    // low nibble is the byte sampled in the last wait
    read_lo_nib_a: assert property (@(posedge clk) disable iff (!arst_n)
        state_ff == ST_DLO |-> !mux_nibble_bus_oe_n &&
        mux_nibble_bus_o == $past(read_data[3:0], 2))
        else $error("low nibble wrong");
    // read request only in the clock after the first host turnaround clock of a read
    read_req_a: assert property (@(posedge clk) disable iff (!arst_n)
        read_req |-> $past(state_ff) == ST_HTAR0 && !is_write_ff)
        else $error("read request misplaced");
    // handed byte is the two data nibbles, low first
    write_byte_a: assert property (@(posedge clk) disable iff (!arst_n)
        write_strobe |-> write_byte == {$past(mux_nibble_bus_i), $past(mux_nibble_bus_i, 2)})
        else $error("write byte wrong");
    // foreign type nibble leads to skip
    type_skip_a: assert property (@(posedge clk) disable iff (!arst_n)
        state_ff == ST_TYPE && frame_strobe_n && mux_nibble_bus_i[3:2] != 2'b01
        |=> state_ff == ST_SKIP)
        else $error("foreign cycle not skipped");
    // skip held while an operation is pending
    skip_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
        state_ff == ST_SKIP && frame_strobe_n && op_pending |=> state_ff == ST_SKIP)
        else $error("skip left early");
    // standby once frame high and nothing pending
    skip_exit_a: assert property (@(posedge clk) disable iff (!arst_n)
        state_ff == ST_SKIP && frame_strobe_n && !op_pending |=> state_ff == ST_IDLE)
        else $error("skip not left");
    // no cycle starts while frame strobe high
    idle_frame_a: assert property (@(posedge clk) disable iff (!arst_n)
        state_ff == ST_IDLE && frame_strobe_n |=> state_ff == ST_IDLE)
        else $error("start without frame");
    // new start aborts and floats the bus
    restart_float_a: assert property (@(posedge clk) disable iff (!arst_n)
        restart |=> state_ff == ST_TYPE && mux_nibble_bus_oe_n)
        else $error("restart wrong");
    // float in type, write data and last turnaround
    float_turn_a: assert property (@(posedge clk) disable iff (!arst_n)
        state_ff inside {ST_TYPE, ST_WDATA, ST_DTAR1} |-> mux_nibble_bus_oe_n)
        else $error("bus driven in host field");
    addr_stable_a: assert property (@(posedge clk) disable iff (!arst_n)
        state_ff != ST_ADDR |=> $stable(access_addr))
        else $error("address changed outside field");

    // main scenarios reached
    read_cov_c:  cover property (@(posedge clk) state_ff == ST_DHI);
    write_cov_c: cover property (@(posedge clk) write_strobe);
    skip_cov_c:  cover property (@(posedge clk) state_ff == ST_SKIP);
    restart_cov_c: cover property (@(posedge clk) restart);
    hold_cov_c:  cover property (@(posedge clk) state_ff == ST_SKIP && op_pending);
endmodule // lpc_memory_cycle_target
`default_nettype wire

// ---- bench/host_model.sv ----
// host side model: drives frame strobe and nibbles, records the bus
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic       clk,
    input  wire logic [3:0] dev_o,
    input  wire logic       dev_oe_n,
    output logic            frame_strobe_n,
    output logic      [3:0] bus
);
    logic       [3:0] drv;
    logic             drv_en;
    logic       [3:0] obs [0:19];
    logic             obs_oe_n [0:19];
    // wire level, pulled up to ones when nobody drives
    assign bus = !dev_oe_n ? dev_o : (drv_en ? drv : 4'hf);
    initial begin
        frame_strobe_n = 1'b1;
        drv = 4'hf;
        drv_en = 1'b0;
    end
    // one whole cycle; pre adds an earlier strobe-low clock with another nibble
    task automatic xfer(input logic [3:0] typ, input logic [31:0] addr,
                        input logic [7:0] wd, input bit pre);
        logic [3:0] hv [1:20];
        logic       he [1:20];
        for (int k = 1; k <= 20; k++) begin
            hv[k] = 4'hf;
            he[k] = (k <= 11);
        end
        hv[1] = 4'h0;
        hv[2] = typ;
        for (int i = 0; i < 8; i++) hv[3 + i] = addr[31 - 4 * i -: 4];
        if (typ[1]) begin
            hv[11] = wd[3:0];
            hv[12] = wd[7:4];
            he[12] = 1'b1;
            he[13] = 1'b1;
        end
        if (pre) begin
            @(posedge clk);
            frame_strobe_n <= 1'b0;
            drv <= 4'ha;
            drv_en <= 1'b1;
        end
        // host ones then float, samples on rising edge
        for (int k = 1; k <= 20; k++) begin
            @(posedge clk);
            obs[k - 1] = bus;
            obs_oe_n[k - 1] = dev_oe_n;
            frame_strobe_n <= (k != 1);
            drv <= hv[k];
            drv_en <= he[k];
        end
    endtask
    // partial read: start, type, address nibbles, then cut off
    task automatic cut(input int n);
        for (int k = 1; k <= n; k++) begin
            @(posedge clk);
            frame_strobe_n <= (k != 1);
            drv <= (k == 1) ? 4'h0 : ((k == 2) ? 4'h4 : 4'h9);
            drv_en <= 1'b1;
        end
    endtask
endmodule // host_model
`default_nettype wire

// ---- bench/lpc_memory_cycle_target_tb_top.sv ----
// testbench for the memory cycle target with a host model
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; \
    $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module lpc_memory_cycle_target_tb_top;
    logic        clk;
    logic        arst_n;
    logic        frame_strobe_n;
    logic [3:0]  bus;
    logic [3:0]  dev_o;
    logic        dev_oe_n;
    logic [23:0] access_addr;
    logic        array_select;
    logic        read_req;
    logic [7:0]  read_data;
    logic [7:0]  write_byte;
    logic        write_strobe;
    logic        cycle_busy;
    logic        op_pending;
    int          err_total;
    int          checks;
    int          strobes;
    int          reqs;

    lpc_memory_cycle_target u_lpc_memory_cycle_target (
        .clk(clk), .arst_n(arst_n), .frame_strobe_n(frame_strobe_n),
        .mux_nibble_bus_i(bus), .mux_nibble_bus_o(dev_o), .mux_nibble_bus_oe_n(dev_oe_n),
        .access_addr(access_addr), .array_select(array_select), .read_req(read_req),
        .read_data(read_data), .write_byte(write_byte), .write_strobe(write_strobe),
        .cycle_busy(cycle_busy), .op_pending(op_pending)
    );
    host_model u_host_model (
        .clk(clk), .dev_o(dev_o), .dev_oe_n(dev_oe_n),
        .frame_strobe_n(frame_strobe_n), .bus(bus)
    );

    // clock generation
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // pulse counters
    always @(posedge clk) begin
        if (write_strobe === 1'b1) strobes++;
        if (read_req === 1'b1) reqs++;
    end

    task automatic results();
        if (err_total == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic do_read(input logic [3:0] typ, input logic [31:0] addr,
                           input logic [7:0] rd, input bit pre);
        int r0;
        r0 = reqs;
        @(posedge clk);
        read_data <= rd;
        u_host_model.xfer(typ, addr, 8'h00, pre);
        for (int k = 1; k <= 12; k++) `CHK(u_host_model.obs_oe_n[k], 1'b1)
        for (int k = 13; k <= 18; k++) `CHK(u_host_model.obs_oe_n[k], 1'b0)
        `CHK(u_host_model.obs[13], mem_cycle_pkg::WAIT_SYNC_CODE)
        `CHK(u_host_model.obs[14], mem_cycle_pkg::WAIT_SYNC_CODE)
        `CHK(u_host_model.obs[15], mem_cycle_pkg::READY_SYNC_CODE)
        `CHK(u_host_model.obs[16], rd[3:0])
        `CHK(u_host_model.obs[17], rd[7:4])
        `CHK(u_host_model.obs[18], 4'hf)
        `CHK(u_host_model.obs_oe_n[19], 1'b1)
        `CHK(access_addr, addr[23:0])
        `CHK(array_select, addr[23])
        `CHK(reqs - r0, 1)
    endtask

    task automatic do_write(input logic [3:0] typ, input logic [31:0] addr,
                            input logic [7:0] wd, input bit pre);
        int s0;
        s0 = strobes;
        u_host_model.xfer(typ, addr, wd, pre);
        for (int k = 1; k <= 14; k++) `CHK(u_host_model.obs_oe_n[k], 1'b1)
        `CHK(u_host_model.obs_oe_n[15], 1'b0)
        `CHK(u_host_model.obs[15], mem_cycle_pkg::READY_SYNC_CODE)
        `CHK(u_host_model.obs_oe_n[16], 1'b0)
        `CHK(u_host_model.obs[16], 4'hf)
        `CHK(u_host_model.obs_oe_n[17], 1'b1)
        `CHK(write_byte, wd)
        `CHK(strobes - s0, 1)
        `CHK(access_addr, addr[23:0])
    endtask

    task automatic do_abort(input logic [31:0] addr, input logic [7:0] wd);
        int s0;
        u_host_model.cut(6);
        @(negedge clk);
        `CHK(cycle_busy, 1'b1)
        s0 = strobes;
        u_host_model.xfer(4'h6, addr, wd, 1'b0);
        `CHK(u_host_model.obs_oe_n[15], 1'b0)
        `CHK(u_host_model.obs[15], mem_cycle_pkg::READY_SYNC_CODE)
        `CHK(write_byte, wd)
        `CHK(strobes - s0, 1)
        `CHK(access_addr, addr[23:0])
        `CHK(array_select, addr[23])
    endtask

    task automatic do_foreign(input logic [3:0] typ);
        @(posedge clk);
        op_pending <= 1'b1;
        u_host_model.xfer(typ, 32'h1234_5678, 8'h5a, 1'b0);
        for (int k = 1; k <= 19; k++) `CHK(u_host_model.obs_oe_n[k], 1'b1)
        @(negedge clk);
        `CHK(cycle_busy, 1'b0)
        @(posedge clk);
        op_pending <= 1'b0;
    endtask

    // reset, then the scenarios back to back
    initial begin
        err_total = 0;
        checks = 0;
        strobes = 0;
        reqs = 0;
        arst_n = 1'b0;
        op_pending = 1'b0;
        read_data = 8'h00;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        do_read(4'h4, 32'hffa5_c3e1, 8'h3c, 1'b0);
        do_read(4'h5, 32'h0012_3456, 8'hd7, 1'b1);
        do_write(4'h6, 32'hff80_0010, 8'h40, 1'b0);
        do_write(4'h7, 32'h0070_ffff, 8'hb9, 1'b1);
        do_abort(32'h0080_0042, 8'h96);
        do_foreign(4'h2);
        do_foreign(4'h8);
        do_read(4'h4, 32'h00ff_0001, 8'he2, 1'b0);
        results();
    end
    // watchdog
    initial begin
        repeat (3000) @(posedge clk);
        err_total++;
        results();
    end
endmodule // lpc_memory_cycle_target_tb_top
`default_nettype wire
